/* File: core/display_interrupt_aggregator.v */
// display interrupt aggregator: per-source sticky bits, categories, master enable
//
// Contract
// (RL1) live status register shows each event's raw level, read without side effects
// (RL2) unmasked interrupt is raw event and not the source's mask bit
// (RL3) rising edge of unmasked interrupt sets sticky identity bit until cleared
// (RL4) writing one clears an identity bit; writing zero leaves it
// (RL5) identity bit holds two events; clearing re-sets it if second was stored
// (RL6) enabled interrupt is sticky identity bit and the source enable bit
// (RL7) enabled interrupts ORed per category into readable pending bits in control
// (RL8) all pending category bits ORed into one combined display interrupt
// (RL9) combined interrupt ANDed with master enable bit 31 gives enabled output
// (RL10) display enabled interrupt is delivered to graphics interrupt processing logic
// (RL11) setting master enable again with pending bits re-asserts the output
// (RL12) software reads and clears the graphics primary register when servicing
// (RL13) software clears master enable bit before ending service
// (RL14) software reads pending then identity bits, writing ones back repeatedly
// (RL15) software may recheck pending bits, finally sets master enable again
// (RL16) one clock domain; reset clears sticky bits, queues and master enable
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "disp_irq_defines.vh"

module display_interrupt_aggregator #(
    parameter CATEGORIES = 4,
    parameter SOURCES    = 32
) (
    // clock and reset
    input  wire                             clk,
    input  wire                             srst,
    // first-level interrupt events, category c owns bits [c*SOURCES +: SOURCES]
    input  wire [CATEGORIES*SOURCES-1:0]    event_in,
    // register port
    input  wire [`ADDR_W-1:0]               addr,
    input  wire [31:0]                      wdata,
    input  wire                             wr_en,
    input  wire                             rd_en,
    output reg  [31:0]                      rdata,
    // to graphics interrupt processing
    output wire                             display_enabled_irq,
    // local status interrupt
    output wire                             irq
);

    localparam N = CATEGORIES * SOURCES;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    reg  [N-1:0] event_meta;
    reg  [N-1:0] event_sync;

    // events may come from other domains; sample into clk only [RL16]
    always @(posedge clk) begin
        if (srst) begin
            event_meta <= {N{1'b0}};
            event_sync <= {N{1'b0}};
        end else begin
            event_meta <= event_in;
            event_sync <= event_meta;
        end
    end

    // ----------------------------------------------------------------
    // software state
    // ----------------------------------------------------------------
    reg  [N-1:0]              source_mask_register;
    reg  [N-1:0]              source_enable_register;
    reg                       master_enable;
    reg  [`AGG_EV_W-1:0]      agg_status;
    reg  [`AGG_EV_W-1:0]      agg_enable;
    wire [N-1:0]              sticky_identity_register;
    wire [N-1:0]              queued_bits;
    wire [N-1:0]              drop_bits;
    wire [N-1:0]              clear_bits;
    wire [CATEGORIES-1:0]     pending;
    wire                      combined_irq;

    // ----------------------------------------------------------------
    // address decode helpers
    // ----------------------------------------------------------------
    // per-category bank hit: offset within a bank selects the category
    function hit_bank;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] base;
        input integer       cat;
        begin
            hit_bank = (a == base + cat[`ADDR_W-1:0]);
        end
    endfunction

    // ----------------------------------------------------------------
    // per-source slots and per-category registers
    // ----------------------------------------------------------------
    genvar c;
    genvar s;
    generate
        for (c = 0; c < CATEGORIES; c = c + 1) begin : g_cat
            wire wr_mask;
            wire wr_ident;
            wire wr_enable;
            wire [SOURCES-1:0] enabled_bits;

            assign wr_mask   = wr_en & hit_bank(addr, `REG_MASK_BASE, c);
            assign wr_ident  = wr_en & hit_bank(addr, `REG_IDENT_BASE, c);
            assign wr_enable = wr_en & hit_bank(addr, `REG_ENABLE_BASE, c);

            // write-one-to-clear, zero leaves the bit [RL4]
            assign clear_bits[c*SOURCES +: SOURCES] =
                wr_ident ? wdata[SOURCES-1:0] : {SOURCES{1'b0}};

            // mask and enable registers of this category
            always @(posedge clk) begin
                if (srst) begin
                    source_mask_register[c*SOURCES +: SOURCES]   <= `MASK_RESET;
                    source_enable_register[c*SOURCES +: SOURCES] <= `ENABLE_RESET;
                end else begin
                    if (wr_mask) begin
                        source_mask_register[c*SOURCES +: SOURCES] <= wdata[SOURCES-1:0];
                    end
                    if (wr_enable) begin
                        source_enable_register[c*SOURCES +: SOURCES] <= wdata[SOURCES-1:0];
                    end
                end
            end

            for (s = 0; s < SOURCES; s = s + 1) begin : g_src
                sticky_event_slot u_slot (
                    .clk       (clk),
                    .srst      (srst),
                    .raw_event (event_sync[c*SOURCES+s]),
                    .mask_bit  (source_mask_register[c*SOURCES+s]),
                    .clear_one (clear_bits[c*SOURCES+s]),
                    .sticky    (sticky_identity_register[c*SOURCES+s]),
                    .queued    (queued_bits[c*SOURCES+s]),
                    .dropped   (drop_bits[c*SOURCES+s])
                );
            end

            // enabled interrupts of this category [RL6]
            assign enabled_bits = sticky_identity_register[c*SOURCES +: SOURCES]
                                & source_enable_register[c*SOURCES +: SOURCES];
            assign pending[c] = |enabled_bits;                          // [RL7]
        end
    endgenerate

    // ----------------------------------------------------------------
    // combined and enabled display interrupt
    // ----------------------------------------------------------------
    assign combined_irq = |pending;                                     // [RL8]
    // level gating: clearing then setting bit 31 gives a fresh edge [RL11]
    assign display_enabled_irq = combined_irq & master_enable;          // [RL9] [RL10]

    // ----------------------------------------------------------------
    // control register and local event status
    // ----------------------------------------------------------------
    reg                  prev_out;
    wire [`AGG_EV_W-1:0] agg_events;
    wire [`AGG_EV_W-1:0] agg_clear;
    wire                 wr_ctl;

    assign wr_ctl = wr_en & (addr == `REG_CTL);
    assign agg_events[`AGG_EV_ASSERT]   = display_enabled_irq & ~prev_out;
    assign agg_events[`AGG_EV_OVERFLOW] = |drop_bits;
    assign agg_clear = (wr_en && addr == `REG_AGG_CLEAR) ?
                       wdata[`AGG_EV_W-1:0] : {`AGG_EV_W{1'b0}};

    // master enable, status stickies with set beating clear
    always @(posedge clk) begin
        if (srst) begin
            master_enable <= 1'b0;                                      // [RL16]
            prev_out      <= 1'b0;
            agg_status    <= {`AGG_EV_W{1'b0}};
            agg_enable    <= {`AGG_EV_W{1'b0}};
        end else begin
            prev_out <= display_enabled_irq;
            if (wr_ctl) begin
                master_enable <= wdata[`CTL_MASTER_BIT];                // [RL9]
            end
            if (wr_en && addr == `REG_AGG_ENABLE) begin
                agg_enable <= wdata[`AGG_EV_W-1:0];
            end
            agg_status <= (agg_status & ~agg_clear) | agg_events;
        end
    end

    assign irq = |(agg_status & agg_enable);

    // ----------------------------------------------------------------
    // read mux, data one cycle after the strobe
    // ----------------------------------------------------------------
    reg [31:0] next_rdata;
    integer    k;

    // reads have no side effects on any state [RL1]
    always @* begin
        next_rdata = 32'h00000000;
        for (k = 0; k < CATEGORIES; k = k + 1) begin
            if (hit_bank(addr, `REG_LIVE_BASE, k)) begin
                next_rdata[SOURCES-1:0] = event_sync[k*SOURCES +: SOURCES];      // [RL1]
            end else if (hit_bank(addr, `REG_MASK_BASE, k)) begin
                next_rdata[SOURCES-1:0] = source_mask_register[k*SOURCES +: SOURCES];
            end else if (hit_bank(addr, `REG_IDENT_BASE, k)) begin
                next_rdata[SOURCES-1:0] = sticky_identity_register[k*SOURCES +: SOURCES];
            end else if (hit_bank(addr, `REG_ENABLE_BASE, k)) begin
                next_rdata[SOURCES-1:0] = source_enable_register[k*SOURCES +: SOURCES];
            end
        end
        if (addr == `REG_CTL) begin
            next_rdata[CATEGORIES-1:0]     = pending;                   // [RL7]
            next_rdata[`CTL_MASTER_BIT]    = master_enable;
        end else if (addr == `REG_AGG_STATUS) begin
            next_rdata[`AGG_EV_W-1:0] = agg_status;
        end else if (addr == `REG_AGG_ENABLE) begin
            next_rdata[`AGG_EV_W-1:0] = agg_enable;
        end
    end

    // read data register; zero outside read cycles
    always @(posedge clk) begin
        if (srst) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= rd_en ? next_rdata : 32'h00000000;
        end
    end

endmodule

/* File: core/disp_irq_defines.vh */
// constants for the display interrupt aggregator
`ifndef DISP_IRQ_DEFINES_VH
`define DISP_IRQ_DEFINES_VH

// ----------------------------------------------------------------
// register indices (word addresses on the plain register port)
// ----------------------------------------------------------------
`define ADDR_W              6
`define REG_LIVE_BASE       6'h00
`define REG_MASK_BASE       6'h08
`define REG_IDENT_BASE      6'h10
`define REG_ENABLE_BASE     6'h18
`define REG_CTL             6'h20
`define REG_BANK_SPAN       6'h08
`define REG_AGG_STATUS      6'h21
`define REG_AGG_CLEAR       6'h22
`define REG_AGG_ENABLE      6'h23

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTL_MASTER_BIT      31
`define MASK_RESET          32'hffffffff
`define ENABLE_RESET        32'h00000000
`define AGG_EV_ASSERT       0
`define AGG_EV_OVERFLOW     1
`define AGG_EV_W            2

`endif

/* File: core/sticky_event_slot.v */
// one sticky identity bit with room for a second queued event
`timescale 1ns/1ns

module sticky_event_slot (
    // clock and reset
    input  wire clk,
    input  wire srst,
    // event and clear
    input  wire raw_event,
    input  wire mask_bit,
    input  wire clear_one,
    // state
    output reg  sticky,
    output reg  queued,
    output wire dropped
);

    reg  prev_unmasked;
    wire unmasked;
    wire rise;

    // unmasked level and its rising edge
    assign unmasked = raw_event & ~mask_bit;              // [RL2]
    assign rise     = unmasked & ~prev_unmasked;
    // a third event while both places are full is lost
    assign dropped  = rise & sticky & queued & ~clear_one;

    // sticky bit plus one-deep queue; an arriving edge beats a clear
    always @(posedge clk) begin
        if (srst) begin
            prev_unmasked <= 1'b0;
            sticky        <= 1'b0;                        // [RL16]
            queued        <= 1'b0;                        // [RL16]
        end else begin
            prev_unmasked <= unmasked;
            if (clear_one && sticky) begin                // [RL4]
                // second stored event re-arms the bit at once
                sticky <= queued | rise;                  // [RL5]
                queued <= queued & rise;
            end else if (rise) begin
                if (sticky) begin
                    queued <= 1'b1;                       // [RL5]
                end
                sticky <= 1'b1;                           // [RL3]
            end
        end
    end

endmodule

/* File: dv/display_interrupt_aggregator_sva.sv */
// port assertions for the display interrupt aggregator
`timescale 1ns/1ns
`include "disp_irq_defines.vh"

module disp_irq_checker #(
    parameter CATEGORIES = 4,
    parameter SOURCES    = 32
) (
    // clock and reset
    input wire                          clk,
    input wire                          srst,
    // events and register port
    input wire [CATEGORIES*SOURCES-1:0] event_in,
    input wire [`ADDR_W-1:0]            addr,
    input wire [31:0]                   wdata,
    input wire                          wr_en,
    input wire                          rd_en,
    input wire [31:0]                   rdata,
    // outputs
    input wire                          display_enabled_irq,
    input wire                          irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // master enable as last written; only writes move it, so a mirror is exact
    logic master;
    always_ff @(posedge clk) begin
        if (srst)
            master <= 1'b0;
        else if (wr_en && addr == `REG_CTL)
            master <= wdata[31];
    end

    a_live_level: assert property (
        $stable(event_in[31:0]) [*3] ##0 (rd_en && addr == `REG_LIVE_BASE)
        |=> rdata == $past(event_in[31:0])) else $error("live status differs from event");
    a_master_gate: assert property (display_enabled_irq |-> master)
        else $error("output high with master enable clear");
    a_master_off: assert property (
        wr_en && addr == `REG_CTL && !wdata[31] |=> !display_enabled_irq)
        else $error("output stays high after master clear");
    a_pend_or: assert property (rd_en && addr == `REG_CTL |=>
        (rdata[31] && |rdata[3:0]) == $past(display_enabled_irq) && rdata[31] == $past(master))
        else $error("pending bits disagree with output");
    a_sticky_hold: assert property (display_enabled_irq && !wr_en |=> display_enabled_irq)
        else $error("output dropped without a write");
    a_reenable_again: assert property (
        rd_en && addr == `REG_CTL ##1 (|rdata[3:0] && wr_en && addr == `REG_CTL && wdata[31])
        |=> display_enabled_irq) else $error("no reassertion on master set");
    a_ident_keep: assert property (
        rd_en && addr == `REG_IDENT_BASE ##1 wr_en && addr == `REG_IDENT_BASE && wdata == 32'h0
        ##1 rd_en && addr == `REG_IDENT_BASE |=> (rdata & $past(rdata, 2)) == $past(rdata, 2))
        else $error("zero write cleared identity bits");
    a_reset_quiet: assert property ($fell(srst) |-> !display_enabled_irq && !irq)
        else $error("outputs high after reset");

    c_reenable: cover property (wr_en && addr == `REG_CTL && wdata[31] ##1 display_enabled_irq);
    c_local_irq: cover property (irq);
    c_ident_write: cover property (wr_en && addr == `REG_IDENT_BASE && wdata != 32'h0);
endmodule

bind display_interrupt_aggregator disp_irq_checker #(.CATEGORIES(CATEGORIES), .SOURCES(SOURCES))
    chk_i (.clk(clk), .srst(srst), .event_in(event_in), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .display_enabled_irq(display_enabled_irq),
    .irq(irq));

/* File: dv/graphics_primary_model.sv */
// graphics interrupt stage that records display interrupts for software
`timescale 1ns/1ns

module graphics_primary_model (
    // clock and reset
    input  wire clk,
    input  wire srst,
    // display side and servicing software
    input  wire display_enabled_irq,
    input  wire gp_clear,
    output reg  gp_pending
);
    reg seen;

    // only a fresh assertion counts, so a level left high is not seen twice
    always @(posedge clk) begin
        if (srst) begin
            seen       <= 1'b0;
            gp_pending <= 1'b0;
        end else begin
            seen <= display_enabled_irq;
            if (display_enabled_irq && !seen)
                gp_pending <= 1'b1;
            else if (gp_clear)
                gp_pending <= 1'b0;
        end
    end
endmodule

/* File: dv/display_interrupt_aggregator_test.sv */
// self-checking bench for the display interrupt aggregator
`timescale 1ns/1ns
`include "disp_irq_defines.vh"

module display_interrupt_aggregator_test;
    logic         clk = 1'b0;
    logic         srst = 1'b1;
    logic [127:0] event_in = 128'h0;
    logic [5:0]   addr = 6'h00;
    logic [31:0]  wdata = 32'h0;
    logic         wr_en = 1'b0;
    logic         rd_en = 1'b0;
    logic         gp_clear = 1'b0;
    wire  [31:0]  rdata;
    wire          display_enabled_irq;
    wire          irq;
    wire          gp_pending;
    int           n_mismatch = 0;
    int           n_compared = 0;
    int           c;
    logic         rd_due = 1'b0;
    logic [31:0]  rd_exp = 32'h0;
    string        rd_what = "";

    always #4 clk = ~clk;

    display_interrupt_aggregator dut (.clk(clk), .srst(srst), .event_in(event_in),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .display_enabled_irq(display_enabled_irq), .irq(irq));
    graphics_primary_model gp (.clk(clk), .srst(srst), .gp_clear(gp_clear),
        .display_enabled_irq(display_enabled_irq), .gp_pending(gp_pending));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // one bus cycle driven at a rising edge; values read just after an edge are those
    // that stood before it, so a read is compared at the end of the following call
    task automatic bus(input logic w, input logic r, input logic [5:0] a, input logic [31:0] d);
        wr_en <= w;
        rd_en <= r;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        if (rd_due)
            chk(rd_what, rd_exp, rdata);
        rd_due = 1'b0;
    endtask

    // read data stand for one cycle only; the next call looks at them while they stand
    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, 1'b1, a, 32'h0);
        rd_due  = 1'b1;
        rd_exp  = exp;
        rd_what = what;
    endtask

    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 6'h00, 32'h0);
    endtask

    // long enough to pass the two-stage synchroniser both ways
    task automatic pulse(input int i);
        event_in[i] <= 1'b1;
        idle(2);
        event_in[i] <= 1'b0;
        idle(4);
    endtask

    task automatic give_verdict;
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        give_verdict;
    end

    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd(`REG_CTL, 32'h0, "control");
        rd(`REG_MASK_BASE, 32'hffffffff, "mask");
        rd(`REG_IDENT_BASE, 32'h0, "identity");
        rd(6'h30, 32'h0, "unmapped");
        event_in[0] <= 1'b1;
        idle(4);
        rd(`REG_LIVE_BASE, 32'h1, "live");
        rd(`REG_LIVE_BASE, 32'h1, "live");
        rd(`REG_IDENT_BASE, 32'h0, "identity");
        // unmasking a high event is itself a rising edge of the unmasked interrupt
        bus(1'b1, 1'b0, `REG_MASK_BASE, 32'hfffffffe);
        event_in[0] <= 1'b0;
        idle(4);
        rd(`REG_IDENT_BASE, 32'h1, "identity");
        rd(`REG_CTL, 32'h0, "control");
        bus(1'b1, 1'b0, `REG_ENABLE_BASE, 32'h1);
        rd(`REG_CTL, 32'h1, "control");
        chk("display_enabled_irq", 32'h0, 32'(display_enabled_irq));
        bus(1'b1, 1'b0, `REG_CTL, 32'h80000000);
        // a write lands at the edge that ends its call; look one cycle later
        idle(1);
        chk("display_enabled_irq", 32'h1, 32'(display_enabled_irq));
        idle(2);
        chk("gp_pending", 32'h1, 32'(gp_pending));
        // second edge queues, third is lost and flagged locally
        pulse(0);
        pulse(0);
        rd(`REG_AGG_STATUS, 32'h3, "local status");
        bus(1'b1, 1'b0, `REG_AGG_ENABLE, 32'h2);
        idle(1);
        chk("irq", 32'h1, 32'(irq));
        bus(1'b1, 1'b0, `REG_AGG_ENABLE, 32'h0);
        idle(1);
        chk("irq", 32'h0, 32'(irq));
        bus(1'b1, 1'b0, `REG_AGG_CLEAR, 32'h3);
        rd(`REG_AGG_STATUS, 32'h0, "local status");
        rd(`REG_IDENT_BASE, 32'h1, "identity");
        bus(1'b1, 1'b0, `REG_IDENT_BASE, 32'h0);
        rd(`REG_IDENT_BASE, 32'h1, "identity");
        bus(1'b1, 1'b0, `REG_IDENT_BASE, 32'h1);
        rd(`REG_IDENT_BASE, 32'h1, "identity");
        bus(1'b1, 1'b0, `REG_IDENT_BASE, 32'h1);
        rd(`REG_IDENT_BASE, 32'h0, "identity");
        chk("display_enabled_irq", 32'h0, 32'(display_enabled_irq));
        gp_clear <= 1'b1;
        bus(1'b1, 1'b0, `REG_CTL, 32'h0);
        gp_clear <= 1'b0;
        idle(1);
        chk("gp_pending", 32'h0, 32'(gp_pending));
        // each other category feeds its own pending bit; the last is left set
        for (c = 1; c < 4; c++) begin
            bus(1'b1, 1'b0, 6'(`REG_MASK_BASE + c), ~(32'h1 << c));
            bus(1'b1, 1'b0, 6'(`REG_ENABLE_BASE + c), 32'h1 << c);
            pulse(c * 33);
            rd(`REG_CTL, 32'h1 << c, "control");
            chk("display_enabled_irq", 32'h0, 32'(display_enabled_irq));
            if (c < 3)
                bus(1'b1, 1'b0, 6'(`REG_IDENT_BASE + c), 32'h1 << c);
        end
        rd(`REG_CTL, 32'h8, "control");
        bus(1'b1, 1'b0, `REG_CTL, 32'h80000000);
        idle(1);
        chk("display_enabled_irq", 32'h1, 32'(display_enabled_irq));
        idle(2);
        chk("gp_pending", 32'h1, 32'(gp_pending));
        give_verdict;
    end
endmodule
